// [pkg/gpc_regs.vh]
// register indices, field positions and reset values of the gpio port
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

// =====================================================================
// register indices (byte address is four times the index)
// =====================================================================
`define GPC_IDX_PORT     8'h06
`define GPC_IDX_INTCTL   8'h0B
`define GPC_IDX_OPTION   8'h81
`define GPC_IDX_DIR      8'h86
`define GPC_IDX_WPU      8'h95
`define GPC_IDX_IOC      8'h96

// =====================================================================
// field positions
// =====================================================================
`define GPC_OPT_PU_DIS_N 7
`define GPC_OPT_EDGE     6
`define GPC_IC_GIE       7
`define GPC_IC_CHG_IE    3
`define GPC_IC_EXT_IE    4
`define GPC_IC_EXT_FLAG  1
`define GPC_IC_CHG_FLAG  0

// =====================================================================
// reset values
// =====================================================================
`define GPC_RST_PORT     8'h00
`define GPC_RST_DIR      8'hFF
`define GPC_RST_WPU      8'hFF
`define GPC_RST_IOC      4'h0
`define GPC_RST_OPTION   8'hFF
`define GPC_RST_INTCTL   6'h00
`define GPC_RST_LAST     4'h0
`define GPC_OSC_DIR_MASK 8'hC0

`endif

// [core/gpc_pin_sync.v]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gpc_pin_sync (
  input  wire       clk,   // core clock
  input  wire       rst,   // async reset, active high
  input  wire [7:0] d,     // raw pin levels
  output reg  [7:0] q      // filtered levels
);

  reg [7:0] s1_r;
  reg [7:0] s2_r;
  reg [7:0] s3_r;

  // =====================================================================
  // synchroniser chain
  // =====================================================================
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
      q    <= 8'h00;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // a bit changes only once stages two and three agree
      q    <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
    end
  end

endmodule

// [core/gpc_port.v]
// eight-bit gpio port with pull-ups, change detect and wishbone slave
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "gpc_regs.vh"
module gpc_port (
  input  wire        clk,                // core clock, 40 MHz
  input  wire        rst,                // power-on reset, async
  input  wire        master_clear_reset, // sync reset, keeps latch
  input  wire        brownout_reset,     // sync reset, keeps latch
  input  wire        wb_cyc_i,           // wishbone cycle
  input  wire        wb_stb_i,           // wishbone strobe
  input  wire        wb_we_i,            // wishbone write enable
  input  wire [9:0]  wb_adr_i,           // wishbone byte address
  input  wire [3:0]  wb_sel_i,           // wishbone byte selects
  input  wire [31:0] wb_dat_i,           // wishbone write data
  output reg  [31:0] wb_dat_o,           // wishbone read data
  output reg         wb_ack_o,           // wishbone acknowledge
  input  wire [7:0]  pin_i,              // pin levels from pads
  output reg  [7:0]  pin_o,              // pin drive values
  output reg  [7:0]  pin_oe,             // pin drive enables
  output reg  [7:0]  pullup_on,          // weak pull-up enables
  input  wire        xtal_osc_mode,      // crystal or resonator mode
  input  wire        sleep_mode,         // core is asleep
  input  wire        prog_mode,          // serial programming active
  input  wire        debug_data_out,     // programmer data to pin 7
  input  wire        debug_data_drive,   // programmer drives pin 7
  output reg         serial_prog_clock,  // pin 6 level to programmer
  output reg         serial_prog_data,   // pin 7 level to programmer
  output reg         port_change_flag,   // change flag state
  output reg         ext_irq_flag,       // pin 0 edge flag state
  output reg         irq_o,              // interrupt request
  output reg         wake_o              // wake request from sleep
);

  // =====================================================================
  // state
  // =====================================================================
  reg  [7:0] out_r;
  reg  [7:0] dir_r;
  reg  [7:0] wpu_r;
  reg  [3:0] ioc_r;
  reg  [7:0] opt_r;
  reg  [5:0] ictl_r;
  reg        chg_r;
  reg        ext_r;
  reg  [3:0] last_r;
  reg        p0_prev_r;
  reg  [7:0] rdata;
  reg  [7:0] dir_nxt;
  reg  [7:0] wpu_nxt;
  reg  [3:0] ioc_nxt;
  reg  [7:0] opt_nxt;
  reg  [5:0] ictl_nxt;
  reg        chg_nxt;
  reg        ext_nxt;
  wire [7:0] pin_s;
  wire [7:0] dir_eff;
  wire [7:0] oe_nxt;
  wire [7:0] pu_nxt;
  wire [7:0] drv_nxt;
  wire [3:0] mismatch;
  wire       chg_set;
  wire       ext_edge;
  wire       soft_rst;
  wire       req;
  wire       wr;
  wire       rd;
  wire [7:0] idx;

  // =====================================================================
  // address decode
  // =====================================================================
  function hit;
    input [7:0] a;
    input [7:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign rd       = req & ~wb_we_i;
  assign idx      = wb_adr_i[9:2];
  assign soft_rst = master_clear_reset | brownout_reset;

  // =====================================================================
  // pin input synchroniser
  // =====================================================================
  gpc_pin_sync u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pin_i),
    .q   (pin_s)
  );

  // =====================================================================
  // direction, pull-up and drive per pin
  // =====================================================================
  assign dir_eff = dir_r | (xtal_osc_mode ? `GPC_OSC_DIR_MASK : 8'h00);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      if (g == 7) begin : g_dat
        // programming interface owns the data pin
        assign oe_nxt[g]  = prog_mode ? debug_data_drive : ~dir_eff[g];
        assign drv_nxt[g] = prog_mode ? debug_data_out : out_r[g];
      end else if (g == 6) begin : g_clk
        assign oe_nxt[g]  = prog_mode ? 1'b0 : ~dir_eff[g];
        assign drv_nxt[g] = out_r[g];
      end else begin : g_gp
        assign oe_nxt[g]  = ~dir_eff[g];
        assign drv_nxt[g] = out_r[g];
      end
      // pull-up needs enable bit, input direction and global enable
      assign pu_nxt[g] = wpu_r[g]
                       & dir_eff[g]
                       & ~opt_r[`GPC_OPT_PU_DIS_N];
    end
  endgenerate

  // =====================================================================
  // change detection and pin 0 edge
  // =====================================================================
  // a pin edge landing in the same cycle as a port access still raises
  // the change flag while the latch takes the new level
  assign mismatch = ioc_r & (pin_s[7:4] ^ last_r);
  assign chg_set  = |mismatch;
  assign ext_edge = opt_r[`GPC_OPT_EDGE] ? (pin_s[0] & ~p0_prev_r)
                                         : (~pin_s[0] & p0_prev_r);

  // =====================================================================
  // register write path
  // =====================================================================
  always @* begin
    dir_nxt  = dir_r;
    wpu_nxt  = wpu_r;
    ioc_nxt  = ioc_r;
    opt_nxt  = opt_r;
    ictl_nxt = ictl_r;
    chg_nxt  = chg_r;
    ext_nxt  = ext_r;
    if (wr && hit(idx, `GPC_IDX_DIR)) begin
      dir_nxt = wb_dat_i[7:0];
    end
    if (wr && hit(idx, `GPC_IDX_WPU)) begin
      wpu_nxt = wb_dat_i[7:0];
    end
    if (wr && hit(idx, `GPC_IDX_IOC)) begin
      ioc_nxt = wb_dat_i[7:4];
    end
    if (wr && hit(idx, `GPC_IDX_OPTION)) begin
      opt_nxt = wb_dat_i[7:0];
    end
    if (wr && hit(idx, `GPC_IDX_INTCTL)) begin
      ictl_nxt = wb_dat_i[7:2];
      chg_nxt  = wb_dat_i[`GPC_IC_CHG_FLAG];
      ext_nxt  = wb_dat_i[`GPC_IC_EXT_FLAG];
    end
    if (soft_rst) begin
      dir_nxt  = `GPC_RST_DIR;
      wpu_nxt  = `GPC_RST_WPU;
      ioc_nxt  = `GPC_RST_IOC;
      opt_nxt  = `GPC_RST_OPTION;
      ictl_nxt = `GPC_RST_INTCTL;
      ext_nxt  = 1'b0;
    end
    // hardware set wins over a software clear
    if (chg_set) begin
      chg_nxt = 1'b1;
    end
    if (ext_edge) begin
      ext_nxt = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_r  <= `GPC_RST_DIR;
      wpu_r  <= `GPC_RST_WPU;
      ioc_r  <= `GPC_RST_IOC;
      opt_r  <= `GPC_RST_OPTION;
      ictl_r <= `GPC_RST_INTCTL;
      chg_r  <= 1'b0;
      ext_r  <= 1'b0;
    end else begin
      dir_r  <= dir_nxt;
      wpu_r  <= wpu_nxt;
      ioc_r  <= ioc_nxt;
      opt_r  <= opt_nxt;
      ictl_r <= ictl_nxt;
      chg_r  <= chg_nxt;
      ext_r  <= ext_nxt;
    end
  end

  // =====================================================================
  // output latch and last-read latch
  // =====================================================================
  // only power-on reset touches these; the soft resets leave them alone
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r     <= `GPC_RST_PORT;
      last_r    <= `GPC_RST_LAST;
      p0_prev_r <= 1'b0;
    end else begin
      p0_prev_r <= pin_s[0];
      if (wr && hit(idx, `GPC_IDX_PORT)) begin
        out_r <= wb_dat_i[7:0];
      end
      if (req && hit(idx, `GPC_IDX_PORT)) begin
        last_r <= pin_s[7:4];
      end
    end
  end

  // =====================================================================
  // read mux
  // =====================================================================
  always @* begin
    rdata = 8'h00;
    if (hit(idx, `GPC_IDX_PORT)) begin
      rdata = pin_s;
    end
    if (hit(idx, `GPC_IDX_DIR)) begin
      rdata = dir_eff;
    end
    if (hit(idx, `GPC_IDX_WPU)) begin
      rdata = wpu_r;
    end
    if (hit(idx, `GPC_IDX_IOC)) begin
      rdata = {ioc_r, 4'h0};
    end
    if (hit(idx, `GPC_IDX_OPTION)) begin
      rdata = opt_r;
    end
    if (hit(idx, `GPC_IDX_INTCTL)) begin
      rdata = {ictl_r, ext_r, chg_r};
    end
  end

  // =====================================================================
  // wishbone answer
  // =====================================================================
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= {24'h000000, rdata};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // =====================================================================
  // registered pin and status outputs
  // =====================================================================
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_o             <= 8'h00;
      pin_oe            <= 8'h00;
      pullup_on         <= 8'h00;
      serial_prog_clock <= 1'b0;
      serial_prog_data  <= 1'b0;
      port_change_flag  <= 1'b0;
      ext_irq_flag      <= 1'b0;
      irq_o             <= 1'b0;
      wake_o            <= 1'b0;
    end else begin
      pin_o             <= drv_nxt;
      pin_oe            <= oe_nxt;
      pullup_on         <= pu_nxt;
      serial_prog_clock <= pin_s[6];
      serial_prog_data  <= pin_s[7];
      port_change_flag  <= chg_r;
      ext_irq_flag      <= ext_r;
      irq_o             <= ictl_r[`GPC_IC_GIE - 2]
                         & ((ictl_r[`GPC_IC_CHG_IE - 2] & chg_r)
                          | (ictl_r[`GPC_IC_EXT_IE - 2] & ext_r));
      wake_o            <= sleep_mode & chg_r
                         & ictl_r[`GPC_IC_CHG_IE - 2];
    end
  end

endmodule

// [testbench/gpc_checker.sv]
// bus, pin-output and interrupt/wake assertions for the gpio port
`timescale 1ns/1ps
module gpc_checker (
  input wire logic        clk,              // core clock
  input wire logic        rst,              // async reset
  input wire logic        wb_cyc_i,         // bus cycle
  input wire logic        wb_stb_i,         // bus strobe
  input wire logic        wb_we_i,          // bus write
  input wire logic [9:0]  wb_adr_i,         // bus address
  input wire logic [31:0] wb_dat_o,         // read data
  input wire logic        wb_ack_o,         // acknowledge
  input wire logic [7:0]  pin_oe,           // drive enables
  input wire logic [7:0]  pullup_on,        // pull-up enables
  input wire logic        xtal_osc_mode,    // crystal mode
  input wire logic        prog_mode,        // programming mode
  input wire logic        sleep_mode,       // asleep
  input wire logic        port_change_flag, // change flag
  input wire logic        ext_irq_flag,     // edge flag
  input wire logic        irq_o,            // interrupt
  input wire logic        wake_o            // wake request
);
  // ==================================================================
  // properties
  // ==================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_ioc;
    wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h96;
  endsequence
  property p_take;    s_req |=> wb_ack_o; endproperty
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_ioc_low; s_rd_ioc |-> wb_dat_o[3:0] == 4'h0; endproperty
  property p_xtal_oe;
    xtal_osc_mode && $past(xtal_osc_mode) && !prog_mode
      && !$past(prog_mode) |-> pin_oe[7:6] == 2'b00;
  endproperty
  property p_pu_out;
    !prog_mode && !$past(prog_mode) |-> (pin_oe & pullup_on) == 8'h00;
  endproperty
  property p_prog6; $past(prog_mode) |-> !pin_oe[6]; endproperty
  property p_irq; irq_o |-> port_change_flag || ext_irq_flag; endproperty
  property p_wake; wake_o |-> $past(sleep_mode); endproperty
  a_take:     assert property (p_take) else $error("request not acked");
  a_ack_one:  assert property (p_ack_one) else $error("ack too long");
  a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
  a_ioc_low:  assert property (p_ioc_low)
    else $error("change enable low bits set");
  a_xtal_oe:  assert property (p_xtal_oe)
    else $error("pins 7:6 driven in crystal mode");
  a_pu_out:   assert property (p_pu_out)
    else $error("pull-up on a driven pin");
  a_prog6:    assert property (p_prog6)
    else $error("pin 6 driven while programming");
  a_irq:      assert property (p_irq)
    else $error("interrupt without flag");
  a_wake:     assert property (p_wake)
    else $error("wake while awake");
endmodule

bind gpc_port gpc_checker i_chk (.*);

// [testbench/gpc_pin_model.sv]
// board model: drivers, pull-ups and floating lines on the eight pins
`timescale 1ns/1ps
module gpc_pin_model (
  input  wire logic       clk,       // core clock
  input  wire logic [7:0] pin_o,     // design drive values
  input  wire logic [7:0] pin_oe,    // design drive enables
  input  wire logic [7:0] pullup_on, // design pull-ups
  input  wire logic [7:0] ext_val,   // board drive values
  input  wire logic [7:0] ext_drv,   // board drive enables
  output wire logic [7:0] pin_i      // resolved pin levels
);
  logic [7:0] flt;
  initial flt = 8'h00;
  // undriven lines without pull-up keep changing
  always @(posedge clk) flt <= ~flt;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_drv & ext_val)
               | (~pin_oe & ~ext_drv & (pullup_on | flt));
endmodule

// [testbench/tb_gpio_port_pullup_change_irq.sv]
// self-checking bench for the gpio port
`timescale 1ns/1ps
module tb_gpio_port_pullup_change_irq;
  logic clk, rst, master_clear_reset, brownout_reset;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] pin_i, pin_o, pin_oe, pullup_on, ext_val, ext_drv, r;
  logic xtal_osc_mode, sleep_mode, prog_mode, debug_data_out;
  logic debug_data_drive, serial_prog_clock, serial_prog_data;
  logic port_change_flag, ext_irq_flag, irq_o, wake_o;
  int errors, checked;
  wire logic [7:0] flags = {4'h0, irq_o, wake_o, ext_irq_flag,
                            port_change_flag};

  gpc_port i_dut (.*);
  gpc_pin_model i_pins (.*);

  // ==================================================================
  // tasks
  // ==================================================================
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o[7:0];
    chk({7'h0, wb_ack_o}, 8'h01);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // outputs launched one edge after the write are settled here
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(r, e);
  endtask

  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==================================================================
  // clock, watchdog, tests
  // ==================================================================
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    report_and_stop;
  end

  initial begin
    {rst, master_clear_reset, brownout_reset, wb_cyc_i, wb_stb_i} = 5'h10;
    {wb_we_i, xtal_osc_mode, sleep_mode, prog_mode} = 4'h0;
    {debug_data_out, debug_data_drive} = 2'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 46'h0;
    ext_drv = 8'hFF;
    ext_val = 8'h00;
    errors = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(8'h86, 8'hFF);
    rc(8'h95, 8'hFF);
    rc(8'h96, 8'h00);
    rc(8'h81, 8'hFF);
    rc(8'h40, 8'h00);
    chk(pullup_on, 8'h00);
    wb(1'b1, 8'h81, 8'h3F);
    chk(pullup_on, 8'hFF);
    wb(1'b1, 8'h95, 8'h0F);
    chk(pullup_on, 8'h0F);
    wb(1'b1, 8'h86, 8'h3C);
    chk(pullup_on, 8'h0C);
    chk(pin_oe, 8'hC3);
    ext_drv <= 8'h30;
    ext_val <= 8'h10;
    wb(1'b1, 8'h06, 8'hA5);
    chk(pin_o, 8'hA5);
    repeat (6) @(posedge clk);
    rc(8'h06, 8'h9D);
    xtal_osc_mode <= 1'b1;
    wb(1'b1, 8'h86, 8'h00);
    rc(8'h86, 8'hC0);
    chk(pin_oe, 8'h3F);
    prog_mode <= 1'b1;
    debug_data_drive <= 1'b1;
    repeat (2) @(negedge clk);
    chk(pin_oe & 8'hC0, 8'h80);
    chk(pin_o & 8'h80, 8'h00);
    @(posedge clk);
    {prog_mode, debug_data_drive, xtal_osc_mode} <= 3'h0;
    ext_drv <= 8'hFF;
    ext_val <= 8'h20;
    wb(1'b1, 8'h86, 8'hFF);
    wb(1'b1, 8'h96, 8'hFF);
    rc(8'h96, 8'hF0);
    repeat (6) @(posedge clk);
    rc(8'h06, 8'h20);
    wb(1'b1, 8'h0B, 8'h88);
    ext_val <= 8'h24;
    repeat (8) @(negedge clk);
    chk(flags, 8'h00);
    @(posedge clk);
    ext_val <= 8'h04;
    sleep_mode <= 1'b1;
    repeat (8) @(negedge clk);
    chk(flags, 8'h0D);
    wb(1'b1, 8'h0B, 8'h88);
    repeat (3) @(negedge clk);
    chk(flags, 8'h0D);
    @(posedge clk);
    brownout_reset <= 1'b1;
    @(posedge clk);
    brownout_reset <= 1'b0;
    wb(1'b1, 8'h96, 8'hF0);
    wb(1'b1, 8'h0B, 8'h00);
    repeat (3) @(negedge clk);
    chk(flags, 8'h01);
    rc(8'h06, 8'h04);
    wb(1'b1, 8'h0B, 8'h00);
    repeat (3) @(negedge clk);
    chk(flags, 8'h00);
    @(posedge clk);
    ext_val <= 8'h05;
    repeat (8) @(negedge clk);
    chk(flags, 8'h02);
    report_and_stop;
  end
endmodule
